// *** ppc_pkg.sv ***
/*
  Constants for the eight-pin general-purpose port with current-controlled drive.
  Assumes a single-master AHB-Lite bus with word-wide single transfers.
*/
// What this block does
// - Eight bidirectional pins, one bit of each per-pin register each.
// - Direction 1 turns the driver off; 0 drives the latch onto the pin.
// - Pin value reads return sampled pins; writes go into the output latch.
// - Every port write stores the written byte straight into the output latch.
// - Output latch keeps the latest latch or pin value write and feeds pins.
// - Direction governs drivers on analog pins; analog pins read digital zero.
// - Drain-only pins sink only and never drive high.
// - Edge-rate bit set picks limited slew, clear picks maximum slew.
// - Threshold select picks Schmitt or TTL for pin value reads.
// - Analog select leaves digital output alone; digital input reads zero.
// - Analog select bits reset to analog mode.
// - Analog input functions are active only on analog-selected pins.
// - After reset pins take latch data; pin select logic may take over.
// - Enabled analog output wins and forces the digital driver off.
// - Per-pin pull-up enable switches each pull-up.
// - Global enable bit 7 allows limiting on pins with source or sink enables.
// - Level 11=1.0mA, 10=2.0mA, 01=5.0mA, 00=10.0mA; bits 6-2 read zero.
// - Limiting per driver only when its pin enable and global enable are set.
// - Limiting applies whether latch or peripheral drives the pin.
// - Threshold bit 1 selects Schmitt input, 0 selects TTL input.
// - Pull-up is off whenever the pin is an output.
`default_nettype none
package ppc_pkg;
    localparam int unsigned NPINS = 8;
    localparam logic [7:0] OFS_PIN_VALUE   = 8'h00;
    localparam logic [7:0] OFS_LATCH       = 8'h04;
    localparam logic [7:0] OFS_DIRECTION   = 8'h08;
    localparam logic [7:0] OFS_ANALOG      = 8'h0C;
    localparam logic [7:0] OFS_PULLUP      = 8'h10;
    localparam logic [7:0] OFS_DRAIN_ONLY  = 8'h14;
    localparam logic [7:0] OFS_EDGE_RATE   = 8'h18;
    localparam logic [7:0] OFS_THRESHOLD   = 8'h1C;
    localparam logic [7:0] OFS_SRC_CURRENT = 8'h20;
    localparam logic [7:0] OFS_SNK_CURRENT = 8'h24;
    localparam logic [7:0] OFS_DRIVE_CFG   = 8'h28;
    localparam logic [7:0] RST_LATCH       = 8'h00;
    localparam logic [7:0] RST_DIRECTION   = 8'hFF;
    localparam logic [7:0] RST_ANALOG      = 8'hFF;
    localparam logic [7:0] RST_PULLUP      = 8'h00;
    localparam logic [7:0] RST_DRAIN_ONLY  = 8'h00;
    localparam logic [7:0] RST_EDGE_RATE   = 8'hFF;
    localparam logic [7:0] RST_THRESHOLD   = 8'hFF;
    localparam logic [7:0] RST_CURRENT     = 8'h00;
    localparam logic       RST_CCD_ON      = 1'b0;
    localparam logic [1:0] RST_CCD_LEVEL   = 2'b00;
    localparam int unsigned CFG_ON_BIT     = 7;
    localparam int unsigned CFG_LEVEL_LSB  = 0;
    localparam logic [1:0] LEVEL_1MA0      = 2'b11;
    localparam logic [1:0] LEVEL_2MA0      = 2'b10;
    localparam logic [1:0] LEVEL_5MA0      = 2'b01;
    localparam logic [1:0] LEVEL_10MA0     = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ   = 2'b10;
    typedef enum logic [0:0] {
        PPC_BUS_READY = 1'b0,
        PPC_BUS_RDWAIT = 1'b1
    } ppc_bus_state_t;
endpackage
`default_nettype wire

// *** ppc_port.sv ***
/*
  Eight-pin port: AHB-Lite register slave, pin drive, input sampling, current drive.
  Assumes pad comparators supply both Schmitt and TTL levels; pad resolves pin wire.
*/
// Local design decisions: register access over AHB-Lite and the address map.
`default_nettype none
module ppc_port
    import ppc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  pin_st_in,
    input  wire logic [7:0]  pin_ttl_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    input  wire logic [7:0]  periph_sel,
    input  wire logic [7:0]  periph_data,
    input  wire logic [7:0]  analog_out_en,
    output logic      [7:0]  pin_digital_in,
    output logic      [7:0]  analog_in_on,
    output logic      [7:0]  pin_pullup_on,
    output logic      [7:0]  pin_slew_limited,
    output logic      [7:0]  pin_ccd_src_on,
    output logic      [7:0]  pin_ccd_snk_on,
    output logic             ccd_bias_on,
    output logic      [1:0]  ccd_level
);
    // ==========================================
    // Registers and bus state
    // one bit per pin
    logic [7:0]     output_latch;
    logic [7:0]     pin_direction_bits;
    logic [7:0]     analog_select_bits;
    logic [7:0]     pullup_enable_bits;
    logic [7:0]     drain_only_select;
    logic [7:0]     edge_rate_limit;
    logic [7:0]     threshold_select;
    logic [7:0]     source_current_enable;
    logic [7:0]     sink_current_enable;
    logic           current_drive_global_on;
    logic [1:0]     current_level_select;
    ppc_bus_state_t bus_state;
    logic           wr_pend;
    logic [7:0]     wr_addr;
    logic [7:0]     rd_addr;
    logic [7:0]     st_meta;
    logic [7:0]     st_sync;
    logic [7:0]     ttl_meta;
    logic [7:0]     ttl_sync;

    // ==========================================
    // Address phase decode
    wire       addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire       take_wr  = addr_ok && hwrite;
    wire       take_rd  = addr_ok && !hwrite;
    wire [7:0] wdat     = hwdata[7:0];
    wire       wr_pv    = wr_pend && (wr_addr == OFS_PIN_VALUE);
    wire       wr_lat   = wr_pend && (wr_addr == OFS_LATCH);
    wire       wr_dir   = wr_pend && (wr_addr == OFS_DIRECTION);
    wire       wr_ans   = wr_pend && (wr_addr == OFS_ANALOG);
    wire       wr_wpu   = wr_pend && (wr_addr == OFS_PULLUP);
    wire       wr_od    = wr_pend && (wr_addr == OFS_DRAIN_ONLY);
    wire       wr_slr   = wr_pend && (wr_addr == OFS_EDGE_RATE);
    wire       wr_thr   = wr_pend && (wr_addr == OFS_THRESHOLD);
    wire       wr_src   = wr_pend && (wr_addr == OFS_SRC_CURRENT);
    wire       wr_snk   = wr_pend && (wr_addr == OFS_SNK_CURRENT);
    wire       wr_cfg   = wr_pend && (wr_addr == OFS_DRIVE_CFG);

    // ==========================================
    // Input path
    // threshold picks comparator
    wire [7:0] sampled  = (threshold_select & st_sync) | (~threshold_select & ttl_sync);
    wire [7:0] dig_in   = sampled & ~analog_select_bits;
    // port word read back from pins
    wire [7:0] pv_read  = dig_in;

    // ==========================================
    // Read mux
    wire [7:0] cfg_read = {current_drive_global_on, 5'b0_0000, current_level_select};
    logic [7:0] rd_byte;
    always_comb begin
        case (rd_addr)
            OFS_PIN_VALUE:   rd_byte = pv_read;
            OFS_LATCH:       rd_byte = output_latch;
            OFS_DIRECTION:   rd_byte = pin_direction_bits;
            OFS_ANALOG:      rd_byte = analog_select_bits;
            OFS_PULLUP:      rd_byte = pullup_enable_bits;
            OFS_DRAIN_ONLY:  rd_byte = drain_only_select;
            OFS_EDGE_RATE:   rd_byte = edge_rate_limit;
            OFS_THRESHOLD:   rd_byte = threshold_select;
            OFS_SRC_CURRENT: rd_byte = source_current_enable;
            OFS_SNK_CURRENT: rd_byte = sink_current_enable;
            OFS_DRIVE_CFG:   rd_byte = cfg_read;
            default:         rd_byte = 8'h00;
        endcase
    end

    // ==========================================
    // Output path
    // latch unless pin select takes over
    wire [7:0] drv_data = (periph_sel & periph_data) | (~periph_sel & output_latch);
    // direction and analog output gate driver
    wire [7:0] drv_en   = ~pin_direction_bits & ~analog_out_en;
    wire [7:0] next_oe  = drv_en & ~(drain_only_select & drv_data);
    wire [7:0] next_out = drv_data & ~drain_only_select;
    wire [7:0] ccd_all  = {8{current_drive_global_on}};

    // ==========================================
    // Bus slave sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= PPC_BUS_READY;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            rd_addr   <= 8'h00;
            hresp     <= 1'b0;
        end else begin
            hresp   <= 1'b0;
            wr_pend <= take_wr && (bus_state == PPC_BUS_READY);
            case (bus_state)
                PPC_BUS_READY: begin
                    if (take_rd) begin
                        bus_state <= PPC_BUS_RDWAIT;
                        hreadyout <= 1'b0;
                        rd_addr   <= haddr[7:0];
                    end
                    if (take_wr) begin
                        wr_addr <= haddr[7:0];
                    end
                end
                PPC_BUS_RDWAIT: begin
                    bus_state <= PPC_BUS_READY;
                    hreadyout <= 1'b1;
                    hrdata    <= {24'h00_0000, rd_byte};
                end
                default: begin
                    bus_state <= PPC_BUS_READY;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_latch            <= RST_LATCH;
            pin_direction_bits      <= RST_DIRECTION;
            analog_select_bits      <= RST_ANALOG;
            pullup_enable_bits      <= RST_PULLUP;
            drain_only_select       <= RST_DRAIN_ONLY;
            edge_rate_limit         <= RST_EDGE_RATE;
            threshold_select        <= RST_THRESHOLD;
            source_current_enable   <= RST_CURRENT;
            sink_current_enable     <= RST_CURRENT;
            current_drive_global_on <= RST_CCD_ON;
            current_level_select    <= RST_CCD_LEVEL;
        end else begin
            // either write lands in the latch
            if (wr_pv || wr_lat) output_latch <= wdat;
            if (wr_dir) pin_direction_bits <= wdat;
            if (wr_ans) analog_select_bits <= wdat;
            if (wr_wpu) pullup_enable_bits <= wdat;
            if (wr_od)  drain_only_select <= wdat;
            if (wr_slr) edge_rate_limit <= wdat;
            if (wr_thr) threshold_select <= wdat;
            if (wr_src) source_current_enable <= wdat;
            if (wr_snk) sink_current_enable <= wdat;
            if (wr_cfg) begin
                current_drive_global_on <= wdat[CFG_ON_BIT];
                current_level_select    <= wdat[CFG_LEVEL_LSB +: 2];
            end
        end
    end

    // ==========================================
    // Pin synchronisers
    // two stages before any use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_meta  <= 8'h00;
            st_sync  <= 8'h00;
            ttl_meta <= 8'h00;
            ttl_sync <= 8'h00;
        end else begin
            st_meta  <= pin_st_in;
            st_sync  <= st_meta;
            ttl_meta <= pin_ttl_in;
            ttl_sync <= ttl_meta;
        end
    end

    // ==========================================
    // Registered pad controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out          <= 8'h00;
            pin_oe           <= 8'h00;
            pin_digital_in   <= 8'h00;
            analog_in_on     <= 8'h00;
            pin_pullup_on    <= 8'h00;
            pin_slew_limited <= 8'h00;
            pin_ccd_src_on   <= 8'h00;
            pin_ccd_snk_on   <= 8'h00;
            ccd_bias_on      <= 1'b0;
            ccd_level        <= 2'b00;
        end else begin
            pin_out          <= next_out;
            pin_oe           <= next_oe;
            pin_digital_in   <= dig_in;
            analog_in_on     <= analog_select_bits;
            pin_pullup_on    <= pullup_enable_bits & pin_direction_bits;
            pin_slew_limited <= edge_rate_limit;
            pin_ccd_src_on   <= source_current_enable & ccd_all;
            pin_ccd_snk_on   <= sink_current_enable & ccd_all;
            ccd_bias_on      <= current_drive_global_on;
            ccd_level        <= current_level_select;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_taken;
        take_rd && bus_state == PPC_BUS_READY;
    endsequence
    sequence s_rd_done;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_rd_latch;
        s_rd_taken ##0 haddr[7:0] == OFS_LATCH;
    endsequence

    a_read_one_wait: assert property (s_rd_taken |=> s_rd_done)
        else $error("read did not finish after one wait cycle");

    a_pv_write_latch: assert property (wr_pv |=> output_latch == $past(wdat))
        else $error("pin value write missed the latch");

    a_latch_write_drive: assert property (
        wr_lat ##1 (periph_sel == 8'h00 && pin_direction_bits == 8'h00
                    && drain_only_select == 8'h00 && analog_out_en == 8'h00)
        |=> pin_out == $past(output_latch) && pin_oe == 8'hFF)
        else $error("latch value not driven on output pins");

    a_dir_disables: assert property (
        (pin_oe & $past(pin_direction_bits)) == 8'h00)
        else $error("driver on while direction is input");

    a_analog_zero: assert property (
        (pin_digital_in & $past(analog_select_bits)) == 8'h00)
        else $error("analog pin read nonzero");

    a_drain_no_high: assert property (
        (pin_oe & pin_out & $past(drain_only_select)) == 8'h00)
        else $error("drain-only pin driven high");

    a_aout_hiz: assert property (
        (pin_oe & $past(analog_out_en)) == 8'h00)
        else $error("digital driver on under analog output");

    a_slew_follows: assert property (
        wr_slr |=> ##1 pin_slew_limited == $past(wdat, 2))
        else $error("slew select not applied");

    a_ccd_gating: assert property (
        pin_ccd_src_on == ($past(source_current_enable) & {8{$past(current_drive_global_on)}})
        && pin_ccd_snk_on == ($past(sink_current_enable) & {8{$past(current_drive_global_on)}}))
        else $error("current limit gating wrong");

    a_pullup_outputs: assert property (
        (pin_pullup_on & ~$past(pin_direction_bits)) == 8'h00)
        else $error("pull-up on output pin");

    a_cfg_reserved: assert property (
        (s_rd_taken ##0 haddr[7:0] == OFS_DRIVE_CFG) |=> ##1 hrdata[6:2] == 5'b0_0000)
        else $error("config reserved bits nonzero");

    a_sync_latency: assert property (
        (threshold_select == 8'hFF && analog_select_bits == 8'h00)[*3]
        |-> pin_digital_in == $past(pin_st_in, 3))
        else $error("input sampling latency wrong");

    // ==========================================
    // Pad follow checks
    a_aselect_follows: assert property ($past(hresetn) |->
        analog_in_on == $past(analog_select_bits))
        else $error("analog input enables not following select bits");

    a_pullup_enable: assert property (
        pin_pullup_on == ($past(pullup_enable_bits) & $past(pin_direction_bits)))
        else $error("pull-up output not following enables");

    a_level_follows: assert property (
        ccd_bias_on == $past(current_drive_global_on)
        && ccd_level == $past(current_level_select))
        else $error("drive level outputs not following config");

    a_latch_default: assert property (
        ((pin_out ^ $past(output_latch)) & ~$past(periph_sel)
         & ~$past(drain_only_select)) == 8'h00)
        else $error("pin data not taken from the latch");

    a_ttl_latency: assert property (
        (threshold_select == 8'h00 && analog_select_bits == 8'h00)[*3]
        |-> pin_digital_in == $past(pin_ttl_in, 3))
        else $error("TTL input path wrong");

    a_rd_latch_data: assert property (
        s_rd_latch |=> ##1 hrdata[7:0] == $past(output_latch))
        else $error("latch read back wrong");

    a_latch_write: assert property (wr_lat |=> output_latch == $past(wdat))
        else $error("latch write lost");

    a_push_pull: assert property (
        ($past(pin_direction_bits) | $past(analog_out_en) | $past(drain_only_select)
         | pin_oe) == 8'hFF)
        else $error("push-pull pin not driven");

endmodule
`default_nettype wire

// *** ppc_pins_model.sv ***
/*
  Pad-side model of the eight port pins: resolves each wire and feeds both comparators.
  Assumes the bench never drives a pin from outside while the port drives it.
*/
`default_nettype none
module ppc_pins_model (
    input  wire logic       hclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup_on,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ttl_flip,
    output logic      [7:0] pin_st_in,
    output logic      [7:0] pin_ttl_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_q = 8'h00;
    logic [7:0] wire_lvl;
    // Undriven pins without pull-up wander
    always @(posedge hclk) begin
        float_q <= ~float_q;
    end
    assign wire_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                    | (~pin_oe & ~ext_en & (pin_pullup_on | float_q));
    assign pin_st_in  = wire_lvl;
    // Threshold difference on command
    assign pin_ttl_in = wire_lvl ^ ttl_flip;
endmodule
`default_nettype wire

// *** port_pin_control_current_drive_tb.sv ***
/*
  Self-checking bench for the port: AHB-Lite master, read scoreboard, pad checks.
  Assumes the pad model loops driven pins back to both comparator inputs.
*/
`default_nettype none
module port_pin_control_current_drive_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0]  htrans = 2'b00, ccd_level;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, ccd_bias_on;
    logic [7:0]  pin_st_in, pin_ttl_in, pin_out, pin_oe, pin_digital_in, analog_in_on;
    logic [7:0]  pin_pullup_on, pin_slew_limited, pin_ccd_src_on, pin_ccd_snk_on;
    logic [7:0]  periph_sel = 8'h00, periph_data = 8'h00, analog_out_en = 8'h00;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, ttl_flip = 8'h00, v, v2;
    logic [31:0] exp_q[$];
    logic [7:0]  ra[11];
    logic [7:0]  re[11];
    int          fails = 0, samples_checked = 0, seed = 84403;

    always #20 hclk = ~hclk;

    ppc_port i_ppc_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_st_in(pin_st_in),
        .pin_ttl_in(pin_ttl_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_sel(periph_sel),
        .periph_data(periph_data), .analog_out_en(analog_out_en),
        .pin_digital_in(pin_digital_in), .analog_in_on(analog_in_on),
        .pin_pullup_on(pin_pullup_on), .pin_slew_limited(pin_slew_limited),
        .pin_ccd_src_on(pin_ccd_src_on), .pin_ccd_snk_on(pin_ccd_snk_on),
        .ccd_bias_on(ccd_bias_on), .ccd_level(ccd_level));
    ppc_pins_model i_ppc_pins_model (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_on(pin_pullup_on), .ext_en(ext_en), .ext_val(ext_val),
        .ttl_flip(ttl_flip), .pin_st_in(pin_st_in), .pin_ttl_in(pin_ttl_in));

    // ==========================================
    // Compare and closing tasks
    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_pad(input logic [7:0] g, input logic [7:0] e);
        chk_rd({24'h0000_00, g}, {24'h0000_00, e});
    endtask
    task automatic summarize();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================
    // Bus master, called just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0000_00, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h0000_00, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0000_00, e});
        xfer(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic settle();
        repeat (5) @(posedge hclk);
    endtask

    // ==========================================
    // Read monitor: completed data phase against oldest note
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            rd_ph <= 1'b0;
            chk_rd(hrdata, exp_q.pop_front());
        end
        if (hsel && hreadyout && htrans == HTRANS_NONSEQ && !hwrite) rd_ph <= 1'b1;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        summarize();
    end

    // ==========================================
    // Main sequence
    initial begin
        ra = '{OFS_LATCH, OFS_DIRECTION, OFS_ANALOG, OFS_PULLUP, OFS_DRAIN_ONLY, OFS_EDGE_RATE,
               OFS_THRESHOLD, OFS_SRC_CURRENT, OFS_SNK_CURRENT, OFS_DRIVE_CFG, 8'h30};
        re = '{RST_LATCH, RST_DIRECTION, RST_ANALOG, RST_PULLUP, RST_DRAIN_ONLY, RST_EDGE_RATE,
               RST_THRESHOLD, RST_CURRENT, RST_CURRENT, {RST_CCD_ON, 5'b0_0000, RST_CCD_LEVEL},
               8'h00};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk_pad(pin_oe, 8'h00);
        chk_pad(analog_in_on, 8'hFF);
        for (int i = 0; i < 11; i++) rd(ra[i], re[i]);
        chk_pad({7'b000_0000, hresp}, 8'h00);
        v = 8'($random(seed));
        v2 = 8'($random(seed));
        wr(OFS_ANALOG, 8'h00);
        wr(OFS_DIRECTION, 8'h00);
        wr(OFS_LATCH, v);
        settle();
        chk_pad(pin_oe, 8'hFF);
        chk_pad(pin_out, v);
        rd(OFS_PIN_VALUE, v);
        wr(OFS_PIN_VALUE, v2);
        settle();
        rd(OFS_LATCH, v2);
        chk_pad(pin_out, v2);
        wr(OFS_ANALOG, 8'hFF);
        settle();
        rd(OFS_PIN_VALUE, 8'h00);
        chk_pad(pin_digital_in, 8'h00);
        chk_pad(pin_oe, 8'hFF);
        chk_pad(analog_in_on, 8'hFF);
        wr(OFS_ANALOG, 8'h00);
        wr(OFS_DRAIN_ONLY, 8'hFF);
        settle();
        chk_pad(pin_oe, ~v2);
        chk_pad(pin_out, 8'h00);
        wr(OFS_DRAIN_ONLY, 8'h00);
        v = 8'($random(seed));
        periph_sel <= 8'hF0;
        periph_data <= v;
        analog_out_en <= 8'h0F;
        settle();
        chk_pad(pin_out & 8'hF0, v & 8'hF0);
        chk_pad(pin_oe, 8'hF0);
        periph_sel <= 8'h00;
        analog_out_en <= 8'h00;
        wr(OFS_DIRECTION, 8'h0F);
        wr(OFS_PULLUP, 8'hFF);
        settle();
        chk_pad(pin_pullup_on, 8'h0F);
        wr(OFS_PULLUP, 8'h00);
        wr(OFS_DIRECTION, 8'hFF);
        v = 8'($random(seed));
        ext_en <= 8'hFF;
        ext_val <= v;
        settle();
        rd(OFS_PIN_VALUE, v);
        chk_pad(pin_digital_in, v);
        // thresholds change with no peripheral active
        ttl_flip <= 8'hFF;
        wr(OFS_THRESHOLD, 8'h00);
        settle();
        rd(OFS_PIN_VALUE, ~v);
        wr(OFS_THRESHOLD, 8'hAA);
        settle();
        rd(OFS_PIN_VALUE, v ^ 8'h55);
        v = 8'($random(seed));
        wr(OFS_EDGE_RATE, v);
        settle();
        chk_pad(pin_slew_limited, v);
        // global enable set before any per-pin enable
        for (int l = 0; l < 4; l++) begin
            wr(OFS_DRIVE_CFG, 8'hFC | 8'(l));
            settle();
            rd(OFS_DRIVE_CFG, 8'h80 | 8'(l));
            chk_pad({6'b00_0000, ccd_level}, 8'(l));
        end
        wr(OFS_SRC_CURRENT, 8'h0F);
        wr(OFS_SNK_CURRENT, 8'hF0);
        settle();
        chk_pad(pin_ccd_src_on, 8'h0F);
        chk_pad(pin_ccd_snk_on, 8'hF0);
        chk_pad({7'b000_0000, ccd_bias_on}, 8'h01);
        wr(OFS_SRC_CURRENT, 8'h00);
        settle();
        chk_pad(pin_ccd_src_on, 8'h00);
        wr(OFS_SNK_CURRENT, 8'h00);
        wr(OFS_DRIVE_CFG, 8'h00);
        settle();
        summarize();
    end
endmodule
`default_nettype wire
